// [include/nfc_pkg.sv]
// Shared constants and types for the NAND flash command controller
package nfc_pkg;

    // Page geometry
    localparam int PAGE_BYTES       = 2112;
    localparam int MAIN_BYTES       = 2048;
    localparam int SPARE_BYTES      = 64;
    localparam int SECTOR_MAIN      = 512;
    localparam int SECTOR_SPARE     = 16;
    localparam int PAGES_PER_BLOCK  = 64;
    localparam int PAGE_BITS        = 6;
    localparam int MAX_PARTIAL_PROG = 4;

    // Address byte layout
    localparam int COL_W      = 12;
    localparam int ROW_W      = 16;
    localparam int LEN_W      = 12;
    localparam int ADDR_COL_LO  = 0;
    localparam int ADDR_COL_HI  = 1;
    localparam int ADDR_ROW_LO  = 2;
    localparam int ADDR_ROW_HI  = 3;

    // Command bytes
    localparam logic [7:0] CMD_READ_SETUP = 8'h00;
    localparam logic [7:0] CMD_READ_GO    = 8'h30;
    localparam logic [7:0] CMD_READ_CB    = 8'h35;
    localparam logic [7:0] CMD_COL_RD     = 8'h05;
    localparam logic [7:0] CMD_COL_RD_GO  = 8'hE0;
    localparam logic [7:0] CMD_LOAD       = 8'h80;
    localparam logic [7:0] CMD_COL_WR     = 8'h85;
    localparam logic [7:0] CMD_PROG_GO    = 8'h10;
    localparam logic [7:0] CMD_ERASE      = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO   = 8'hD0;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_RESET      = 8'hFF;

    // Status byte fields, bit 0 is the first I/O pin
    localparam int STAT_FAIL_BIT  = 0;
    localparam int STAT_READY_BIT = 6;

    // Pin timing in ns and derived cycle counts
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_WP_NS  = 12;
    localparam int T_WC_NS  = 25;
    localparam int T_REA_NS = 20;
    localparam int T_WB_NS  = 100;
    localparam int T_WHR_NS = 60;
    localparam int T_RR_NS  = 20;
    localparam int T_RHW_NS = 30;
    localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WC_CYC  = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REA_CYC = (T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WB_CYC  = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WHR_CYC = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RR_CYC  = (T_RR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RHW_CYC = (T_RHW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Read low phase holds one cycle past access time to sample
    localparam int RD_LOW_CYC = REA_CYC + 1;
    localparam int HIGH_CYC   = WC_CYC - WP_CYC;

    // User operations
    typedef enum logic [3:0] {
        NFC_OP_READ,
        NFC_OP_READ_CB,
        NFC_OP_READ_COL,
        NFC_OP_LOAD,
        NFC_OP_LOAD_COL,
        NFC_OP_CB_LOAD,
        NFC_OP_CONFIRM,
        NFC_OP_ERASE,
        NFC_OP_STATUS,
        NFC_OP_RESET
    } nfc_op_e;

endpackage

// [hdl/nfc_strobe.sv]
// Write and read strobe pulse generator for one bus cycle
module nfc_strobe
    import nfc_pkg::*;
#(
    parameter int WR_LOW = nfc_pkg::WP_CYC,
    parameter int RD_LOW = nfc_pkg::RD_LOW_CYC,
    parameter int HIGH   = nfc_pkg::HIGH_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_start,
    input  wire logic i_read,
    output logic      o_we_n,
    output logic      o_re_n,
    output logic      o_sample,
    output logic      o_done
);
    typedef enum logic [1:0] {NFC_SB_IDLE, NFC_SB_LOW, NFC_SB_HIGH} nfc_sb_e;

    typedef struct packed {
        nfc_sb_e    ph;
        logic [3:0] cnt;
        logic       rd;
        logic       we_n;
        logic       re_n;
    } nfc_sb_s;

    nfc_sb_s q, d;

    // Last low cycle of a read is where the pin data is valid
    assign o_sample = (q.ph == NFC_SB_LOW) && (q.cnt == 4'h0) && q.rd;
    assign o_done   = (q.ph == NFC_SB_HIGH) && (q.cnt == 4'h0);
    assign o_we_n   = q.we_n;
    assign o_re_n   = q.re_n;

    // Low phase, then high phase to fill the cycle time
    always_comb begin
        d = q;
        case (q.ph)
            NFC_SB_IDLE: begin
                if (i_start) begin
                    d.ph   = NFC_SB_LOW;
                    d.rd   = i_read;
                    d.cnt  = i_read ? 4'(RD_LOW - 1) : 4'(WR_LOW - 1);
                    d.we_n = i_read;
                    d.re_n = !i_read;
                end
            end
            NFC_SB_LOW: begin
                if (q.cnt == 4'h0) begin
                    d.ph   = NFC_SB_HIGH;
                    d.cnt  = 4'(HIGH - 1);
                    d.we_n = 1'b1;
                    d.re_n = 1'b1;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            default: begin
                if (q.cnt == 4'h0) begin
                    d.ph = NFC_SB_IDLE;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
        endcase
    end

    // Strobes idle high after reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '{ph: NFC_SB_IDLE, cnt: 4'h0, rd: 1'b0,
                   we_n: 1'b1, re_n: 1'b1};
        end else begin
            q <= d;
        end
    end
endmodule

// [hdl/nfc_ctrl.sv]
// Host-side NAND flash controller: sequences commands over the pins
// How it works
// - Address goes col low, col high nibble, row low, row high.
// - Command, address and data bytes use distinct latch settings.
// - During read busy strobes stay high; only status and reset go.
// - Page read is setup command, four address bytes, confirm.
// - Read column change: command, two column bytes, confirm command.
// - Program loads start on a main-area sector boundary; at most four confirms until an NFC_OP_LOAD to another page or an erase of its block resets the count.
// - Program is load command, address, data, then program confirm.
// - Write column change redirects following data bytes in the page.
// - Erase is setup command, two row address bytes, then start command.
// - Copy-back program: copy load, destination address, data, confirm.
module nfc_ctrl
    import nfc_pkg::*;
(
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire logic                   i_cmd_valid,
    input  wire nfc_pkg::nfc_op_e       i_op,
    input  wire logic [nfc_pkg::COL_W-1:0] i_col,
    input  wire logic [nfc_pkg::ROW_W-1:0] i_row,
    input  wire logic [nfc_pkg::LEN_W-1:0] i_len,
    input  wire logic                   i_allow_write,
    output logic                        o_cmd_ready,
    input  wire logic [7:0]             i_wr_data,
    input  wire logic                   i_wr_valid,
    output logic                        o_wr_ready,
    output logic [7:0]                  o_rd_data,
    output logic                        o_rd_valid,
    output logic [7:0]                  o_status,
    output logic                        o_done,
    output logic                        o_err,
    output logic                        o_busy,
    output logic                        o_ce_n,
    output logic                        o_cle,
    output logic                        o_ale,
    output logic                        o_we_n,
    output logic                        o_re_n,
    output logic                        o_wp_n,
    output logic [7:0]                  o_io_out,
    output logic                        o_io_oe_n,
    input  wire logic [7:0]             i_io_in,
    input  wire logic                   i_ready_busy_n
);
    typedef enum logic [3:0] {
        NFC_IDLE, NFC_CMD1, NFC_ADDR, NFC_WDATA, NFC_CMD2, NFC_GAP,
        NFC_RBWAIT, NFC_RDATA, NFC_SCMD, NFC_SREAD, NFC_DONE
    } nfc_st_e;

    // Static shape of each operation
    typedef struct packed {
        logic [7:0] c1;
        logic [7:0] c2;
        logic       hc2;
        logic       ha;
        logic [1:0] af;
        logic [1:0] al;
        logic       wr;
        logic       rd;
        logic       wrb;
        logic       sta;
    } nfc_dec_s;

    typedef struct packed {
        nfc_st_e          st;
        nfc_st_e          nxt;
        nfc_op_e          op;
        logic             sent;
        logic [1:0]       aidx;
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
        logic [LEN_W-1:0] len;
        logic [7:0]       wcnt;
        logic             ce_n;
        logic             cle;
        logic             ale;
        logic             oe_n;
        logic [7:0]       io;
        logic [7:0]       rdat;
        logic             rval;
        logic [7:0]       stat;
        logic             done;
        logic             err;
        logic [2:0]       pcnt;
        logic [ROW_W-1:0] prow;
        logic             wp_n;
    } nfc_ctl_s;

    function automatic nfc_dec_s nfc_decode(input nfc_op_e op);
        nfc_dec_s r;
        r = '{c1: CMD_READ_SETUP, c2: CMD_READ_GO, hc2: 1'b0, ha: 1'b1,
              af: 2'(ADDR_COL_LO), al: 2'(ADDR_ROW_HI), wr: 1'b0,
              rd: 1'b0, wrb: 1'b0, sta: 1'b0};
        case (op)
            NFC_OP_READ: begin
                r.hc2 = 1'b1; r.rd = 1'b1; r.wrb = 1'b1;
            end
            NFC_OP_READ_CB: begin
                r.c2 = CMD_READ_CB; r.hc2 = 1'b1;
                r.rd = 1'b1; r.wrb = 1'b1;
            end
            NFC_OP_READ_COL: begin
                r.c1 = CMD_COL_RD; r.c2 = CMD_COL_RD_GO;
                r.hc2 = 1'b1; r.al = 2'(ADDR_COL_HI); r.rd = 1'b1;
            end
            NFC_OP_LOAD: begin
                r.c1 = CMD_LOAD; r.wr = 1'b1;
            end
            NFC_OP_LOAD_COL: begin
                r.c1 = CMD_COL_WR; r.al = 2'(ADDR_COL_HI);
                r.wr = 1'b1;
            end
            NFC_OP_CB_LOAD: begin
                r.c1 = CMD_COL_WR; r.wr = 1'b1;
            end
            NFC_OP_CONFIRM: begin
                r.c1 = CMD_PROG_GO; r.ha = 1'b0;
                r.wrb = 1'b1; r.sta = 1'b1;
            end
            NFC_OP_ERASE: begin
                r.c1 = CMD_ERASE; r.c2 = CMD_ERASE_GO;
                r.hc2 = 1'b1; r.af = 2'(ADDR_ROW_LO);
                r.wrb = 1'b1; r.sta = 1'b1;
            end
            NFC_OP_STATUS: begin
                r.c1 = CMD_STATUS; r.ha = 1'b0; r.rd = 1'b1;
            end
            default: begin
                r.c1 = CMD_RESET; r.ha = 1'b0; r.wrb = 1'b1;
            end
        endcase
        return r;
    endfunction

    nfc_ctl_s q, d;
    nfc_dec_s dq, di;
    logic     strt, srd, s_sample, s_done;
    logic     col_bad, load_bad, prog_bad, may_go;
    nfc_st_e  fin_st, fin_nxt;
    logic [7:0] fin_cnt;

    nfc_strobe u_strobe (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_start  (strt),
        .i_read   (srd),
        .o_we_n   (o_we_n),
        .o_re_n   (o_re_n),
        .o_sample (s_sample),
        .o_done   (s_done)
    );

    assign dq = nfc_decode(q.op);
    assign di = nfc_decode(i_op);

    // Only status and reset may go while the device is busy
    assign may_go = i_ready_busy_n || (i_op == NFC_OP_STATUS)
                    || (i_op == NFC_OP_RESET);
    assign o_cmd_ready = (q.st == NFC_IDLE) && may_go;
    assign o_wr_ready  = (q.st == NFC_WDATA) && !q.sent;

    // Request checks against page layout and partial program limit
    assign col_bad  = di.ha && (di.af == 2'(ADDR_COL_LO))
                      && (i_col >= COL_W'(PAGE_BYTES));
    assign load_bad = (i_op == NFC_OP_LOAD)
                      && ((i_col[8:0] != 9'h000)
                      || (i_col >= COL_W'(MAIN_BYTES)));
    assign prog_bad = (i_op == NFC_OP_CONFIRM)
                      && (q.pcnt >= 3'(MAX_PARTIAL_PROG));

    // Where to go once the last command, address or data byte of the operation has been latched
    always_comb begin
        fin_st  = NFC_GAP;
        fin_nxt = NFC_DONE;
        fin_cnt = 8'(RHW_CYC);
        if (dq.wrb) begin
            fin_nxt = NFC_RBWAIT;
            fin_cnt = 8'(WB_CYC);
        end else if (dq.rd) begin
            fin_nxt = NFC_RDATA;
            fin_cnt = 8'(WHR_CYC);
        end
    end

    // Main sequencer
    always_comb begin
        d      = q;
        strt   = 1'b0;
        srd    = 1'b0;
        d.rval = 1'b0;
        d.done = 1'b0;
        d.err  = 1'b0;
        d.wp_n = i_allow_write;
        case (q.st)
            NFC_IDLE: begin
                if (i_cmd_valid && may_go) begin
                    if (col_bad || load_bad || prog_bad) begin
                        d.err = 1'b1;
                    end else begin
                        d.op   = i_op;
                        d.col  = i_col;
                        d.row  = i_row;
                        d.len  = i_len;
                        d.aidx = di.af;
                        d.ce_n = 1'b0;
                        d.st   = (i_op == NFC_OP_STATUS) ? NFC_SCMD
                                                         : NFC_CMD1;
                        if (i_op == NFC_OP_LOAD && i_row != q.prow) begin
                            d.prow = i_row;
                            d.pcnt = 3'h0;
                        end else if (i_op == NFC_OP_CONFIRM) begin
                            d.pcnt = q.pcnt + 3'h1;
                        end else if (i_op == NFC_OP_ERASE
                            && i_row[ROW_W-1:PAGE_BITS]
                               == q.prow[ROW_W-1:PAGE_BITS]) begin
                            d.pcnt = 3'h0;
                        end
                    end
                end
            end
            NFC_CMD1, NFC_CMD2: begin
                if (!q.sent) begin
                    strt   = 1'b1;
                    d.sent = 1'b1;
                end else if (s_done) begin
                    d.sent = 1'b0;
                    if (q.st == NFC_CMD1 && dq.ha) begin
                        d.st = NFC_ADDR;
                    end else if (q.st == NFC_CMD1 && dq.hc2) begin
                        d.st = NFC_CMD2;
                    end else begin
                        d.st   = fin_st;
                        d.nxt  = fin_nxt;
                        d.wcnt = fin_cnt;
                    end
                end
            end
            NFC_ADDR: begin
                if (!q.sent) begin
                    strt   = 1'b1;
                    d.sent = 1'b1;
                end else if (s_done) begin
                    d.sent = 1'b0;
                    if (q.aidx != dq.al) begin
                        d.aidx = q.aidx + 2'h1;
                    end else if (dq.wr && q.len != '0) begin
                        d.st = NFC_WDATA;
                    end else if (dq.hc2) begin
                        d.st = NFC_CMD2;
                    end else begin
                        d.st   = fin_st;
                        d.nxt  = fin_nxt;
                        d.wcnt = fin_cnt;
                    end
                end
            end
            NFC_WDATA: begin
                if (!q.sent) begin
                    if (i_wr_valid) begin
                        d.io   = i_wr_data;
                        strt   = 1'b1;
                        d.sent = 1'b1;
                    end
                end else if (s_done) begin
                    d.sent = 1'b0;
                    d.len  = q.len - LEN_W'(1);
                    if (q.len == LEN_W'(1)) begin
                        d.st   = fin_st;
                        d.nxt  = fin_nxt;
                        d.wcnt = fin_cnt;
                    end
                end
            end
            NFC_GAP: begin
                if (q.wcnt <= 8'h1) begin
                    d.st = q.nxt;
                end else begin
                    d.wcnt = q.wcnt - 8'h1;
                end
            end
            NFC_RBWAIT: begin
                // Strobes stay idle high while the device works
                if (i_ready_busy_n) begin
                    if (dq.sta) begin
                        d.st = NFC_SCMD;
                    end else if (dq.rd) begin
                        d.st   = NFC_GAP;
                        d.nxt  = NFC_RDATA;
                        d.wcnt = 8'(RR_CYC);
                    end else begin
                        d.st = NFC_DONE;
                    end
                end
            end
            NFC_RDATA: begin
                if (q.len == '0) begin
                    d.st   = NFC_GAP;
                    d.nxt  = NFC_DONE;
                    d.wcnt = 8'(RHW_CYC);
                end else if (!q.sent) begin
                    strt   = 1'b1;
                    srd    = 1'b1;
                    d.sent = 1'b1;
                end else begin
                    if (s_sample) begin
                        d.rdat = i_io_in;
                        d.rval = 1'b1;
                    end
                    if (s_done) begin
                        d.sent = 1'b0;
                        d.len  = q.len - LEN_W'(1);
                    end
                end
            end
            NFC_SCMD: begin
                if (!q.sent) begin
                    strt   = 1'b1;
                    d.sent = 1'b1;
                end else if (s_done) begin
                    d.sent = 1'b0;
                    d.st   = NFC_GAP;
                    d.nxt  = NFC_SREAD;
                    d.wcnt = 8'(WHR_CYC);
                end
            end
            NFC_SREAD: begin
                if (!q.sent) begin
                    strt   = 1'b1;
                    srd    = 1'b1;
                    d.sent = 1'b1;
                end else begin
                    if (s_sample) begin
                        d.stat = i_io_in;
                    end
                    if (s_done) begin
                        d.sent = 1'b0;
                        d.st   = NFC_GAP;
                        d.nxt  = NFC_DONE;
                        d.wcnt = 8'(RHW_CYC);
                    end
                end
            end
            default: begin
                d.done = 1'b1;
                d.ce_n = 1'b1;
                d.st   = NFC_IDLE;
            end
        endcase
        // Latch and bus drive follow the state being entered
        d.cle  = (d.st == NFC_CMD1) || (d.st == NFC_CMD2)
                 || (d.st == NFC_SCMD);
        d.ale  = (d.st == NFC_ADDR);
        d.oe_n = !(d.cle || d.ale || d.st == NFC_WDATA);
        if (d.st == NFC_CMD1) begin
            d.io = dq.c1;
            if (q.st == NFC_IDLE) begin
                d.io = di.c1;
            end
        end else if (d.st == NFC_CMD2) begin
            d.io = dq.c2;
        end else if (d.st == NFC_SCMD) begin
            d.io = CMD_STATUS;
        end else if (d.st == NFC_ADDR) begin
            case (d.aidx)
                2'(ADDR_COL_LO): d.io = d.col[7:0];
                2'(ADDR_COL_HI): d.io = {4'h0, d.col[11:8]};
                2'(ADDR_ROW_LO): d.io = d.row[7:0];
                default:         d.io = d.row[15:8];
            endcase
        end
    end

    // Chip deselected and write protected out of reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '{st: NFC_IDLE, nxt: NFC_IDLE, op: NFC_OP_RESET,
                   sent: 1'b0, aidx: 2'h0, col: '0, row: '0, len: '0,
                   wcnt: 8'h0, ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
                   oe_n: 1'b1, io: 8'h0, rdat: 8'h0, rval: 1'b0,
                   stat: 8'h0, done: 1'b0, err: 1'b0, pcnt: 3'h0,
                   prow: '0, wp_n: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign o_rd_data = q.rdat;
    assign o_rd_valid = q.rval;
    assign o_status  = q.stat;
    assign o_done    = q.done;
    assign o_err     = q.err;
    assign o_busy    = (q.st != NFC_IDLE);
    assign o_ce_n    = q.ce_n;
    assign o_cle     = q.cle;
    assign o_ale     = q.ale;
    assign o_wp_n    = q.wp_n;
    assign o_io_out  = q.io;
    assign o_io_oe_n = q.oe_n;
endmodule

// [verification/nfc_flash_model.sv]
// Behavioural flash device answering the controller's pin cycles
module nfc_flash_model (
    input  wire logic       i_clk, i_ce_n, i_cle, i_ale,
    input  wire logic       i_we_n, i_re_n, i_wp_n,
    input  wire logic [7:0] i_io,
    output logic      [7:0] o_io,
    output logic            o_ready_busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] adr = '0;
    logic [11:0] col = '0;
    logic [7:0]  q = '0;
    logic        stat = 0;
    int          na = 0;
    int          bz = 0;
    // Busy timer runs down on the system clock
    always @(posedge i_clk) if (bz > 0) bz--;
    // No command state kept, so address plus confirm always reads
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_cle && (bz == 0 || i_io inside {8'h70, 8'hFF})) begin
            na = 0;
            stat = (i_io == 8'h70);
            if (i_io inside {8'h30, 8'h35, 8'hFF} ||
                i_wp_n && i_io inside {8'h10, 8'hD0})
                bz = 60;
        end else if (!i_ce_n && i_ale) begin
            adr[8*na+:8] = i_io;
            col = adr[11:0];
            na++;
        end
    end
    // Verify loop and ECC hide in busy; fail bit reads pass
    // Column advances on every read strobe fall
    always @(negedge i_re_n) if (!i_ce_n) begin
        q = stat ? {i_wp_n, {2{bz == 0}}, 5'h00}
                 : col[7:0] ^ adr[23:16];
        col++;
    end
    // Released bus shows the inverse, never a stale byte
    assign o_io = (!i_ce_n && !i_re_n) ? q : ~q;
    assign o_ready_busy_n = (bz == 0);
endmodule

// [verification/nfc_ctrl_props.sv]
// Pin protocol checker for the flash controller
module nfc_ctrl_props (
    input wire logic       i_clk, i_reset, i_ready_busy_n, o_ce_n,
    input wire logic       o_cle, o_ale, o_we_n, o_re_n, o_wp_n,
    input wire logic       o_io_oe_n, o_err,
    input wire logic [7:0] o_io_out
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Latch roles at strobe edges
    property p_cmd; $rose(o_we_n) && o_cle |-> !o_ale && !o_ce_n; endproperty
    a_cmd: assert property (p_cmd) else $error("cmd latch");
    property p_adr; $rose(o_we_n) && o_ale |-> !o_cle && o_re_n; endproperty
    a_adr: assert property (p_adr) else $error("addr latch");
    property p_dat; $rose(o_we_n) && !o_cle && !o_ale |-> o_wp_n; endproperty
    a_dat: assert property (p_dat) else $error("data wp");
    property p_rd; $fell(o_re_n) |-> !o_cle && !o_ale && o_io_oe_n; endproperty
    a_rd: assert property (p_rd) else $error("read latch");
    // Strobe widths as chosen: write 3 cycles, read 6
    property p_wew; $fell(o_we_n) |-> !o_we_n[*3] ##1 o_we_n; endproperty
    a_wew: assert property (p_wew) else $error("we width");
    property p_rew; $fell(o_re_n) |-> !o_re_n[*6] ##1 o_re_n; endproperty
    a_rew: assert property (p_rew) else $error("re width");
    // Only status or reset may be written while busy
    property p_bsy; $fell(o_we_n) && !i_ready_busy_n |->
        o_cle && o_io_out inside {8'h70, 8'hFF}; endproperty
    a_bsy: assert property (p_bsy) else $error("cmd busy");
    property p_err; o_err |-> o_ce_n && o_we_n && o_re_n; endproperty
    a_err: assert property (p_err) else $error("refusal pins");
endmodule
bind nfc_ctrl nfc_ctrl_props i_props (.*);

// [verification/tb.sv]
// Self-checking bench: user operations against a behavioural flash
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch %0t got %h", $time, a); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nfc_pkg::*;
    logic i_clk = 0, i_reset = 1, i_cmd_valid = 0, i_allow_write = 0;
    logic i_wr_valid = 1, o_cmd_ready, o_wr_ready, o_rd_valid, o_done;
    logic o_err, o_busy, o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n;
    logic o_io_oe_n, rb_n;
    nfc_op_e i_op = NFC_OP_STATUS;
    logic [11:0] i_col = '0, i_len = '0;
    logic [15:0] i_row = '0;
    logic [7:0]  i_wr_data = 8'hA5, io, m_io, o_rd_data, o_status, o_io_out;
    logic [7:0]  aq[$], rq[$];
    int fail_count = 0, n_checks = 0, cyc = 0, nw = 0;
    nfc_ctrl i_nfc_ctrl (.*, .i_io_in(io), .i_ready_busy_n(rb_n));
    nfc_flash_model i_nfc_flash_model (.i_clk, .i_ce_n(o_ce_n),
        .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n), .i_re_n(o_re_n),
        .i_wp_n(o_wp_n), .i_io(io), .o_io(m_io), .o_ready_busy_n(rb_n));
    assign io = o_io_oe_n ? m_io : o_io_out;
    initial forever #2 i_clk = ~i_clk;
    // Address bytes as latched, read bytes as delivered
    always @(posedge o_we_n) if (o_ale) aq.push_back(o_io_out);
    always @(negedge i_clk) if (o_rd_valid) rq.push_back(o_rd_data);
    // Write bytes handed over, one ready cycle each
    always @(negedge i_clk) if (o_wr_ready) nw++;
    always @(posedge i_clk) if (++cyc == 60000) begin
        fail_count++;
        final_report;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One user operation, then its refusal flag against the expectation
    task automatic run(nfc_op_e op, logic [11:0] c, logic [15:0] r,
                       logic [11:0] n, logic e);
        int k = 0;
        while (o_cmd_ready !== 1'b1) @(negedge i_clk);
        i_op = op;
        i_col = c;
        i_row = r;
        i_len = n;
        i_cmd_valid = 1;
        @(negedge i_clk);
        i_cmd_valid = 0;
        `CHK(o_busy, !e)
        while (o_done !== 1'b1 && o_err !== 1'b1 && k++ < 30000)
            @(negedge i_clk);
        // A hang leaves both low and counts as a mismatch
        `CHK({o_done, o_err}, {!e, e})
    endtask
    task automatic chkq(ref logic [7:0] q[$], input logic [7:0] e[$]);
        `CHK(q.size(), e.size())
        foreach (e[i]) if (i < q.size()) `CHK(q[i], e[i])
        q.delete();
    endtask
    initial begin
        repeat (20) @(negedge i_clk);
        `CHK({o_ce_n, o_wp_n, o_io_oe_n}, 3'b101)
        i_reset = 0;
        run(NFC_OP_READ, 12'h005, 16'h0102, 12'd3, 0);
        chkq(aq, '{8'h05, 8'h00, 8'h02, 8'h01});
        chkq(rq, '{8'h07, 8'h04, 8'h05});
        run(NFC_OP_READ_COL, 12'h1FF, 16'h0102, 12'd2, 0);
        chkq(aq, '{8'hFF, 8'h01});
        chkq(rq, '{8'hFD, 8'h02});
        run(NFC_OP_STATUS, 0, 0, 0, 0);
        `CHK(o_status, 8'h60)
        $display("test read done");
        run(NFC_OP_READ, 12'd2112, 0, 1, 1);
        run(NFC_OP_LOAD, 12'd100, 0, 1, 1);
        run(NFC_OP_LOAD, 12'd2048, 0, 1, 1);
        $display("test refuse done");
        // Write enable needs its setup time before programming
        i_allow_write = 1;
        repeat (30) @(negedge i_clk);
        for (int i = 0; i < 5; i++) begin
            run(NFC_OP_LOAD, 12'd512, 16'h0040, 12'd2, 0);
            run(NFC_OP_LOAD_COL, 12'd1536, 0, 12'd1, 0);
            chkq(aq, '{0, 8'h02, 8'h40, 0, 0, 8'h06});
            `CHK(nw, 3 * (i + 1))
            run(NFC_OP_CONFIRM, 0, 16'h0040, 0, i == 4);
            if (i < 4) `CHK(o_status, 8'hE0)
        end
        run(NFC_OP_ERASE, 0, 16'h0040, 0, 0);
        chkq(aq, '{8'h40, 8'h00});
        `CHK(o_status, 8'hE0)
        run(NFC_OP_LOAD, 12'd0, 16'h0040, 12'd1, 0);
        run(NFC_OP_CONFIRM, 0, 16'h0040, 0, 0);
        $display("test program done");
        run(NFC_OP_READ_CB, 0, 16'h0080, 12'd1, 0);
        chkq(rq, '{8'h80});
        run(NFC_OP_CB_LOAD, 0, 16'h00C0, 0, 0);
        run(NFC_OP_CONFIRM, 0, 16'h00C0, 0, 0);
        `CHK(o_status, 8'hE0)
        run(NFC_OP_RESET, 0, 0, 0, 0);
        $display("test copy done");
        final_report;
    end
endmodule
